// file: verilog/ued_defs.vh
// Constants for the endpoint descriptor control block
`ifndef UED_DEFS_VH
`define UED_DEFS_VH
// ================================================================
// Register offsets
`define UED_REG_CTRL     4'h0
`define UED_REG_BASE     4'h4
`define UED_REG_STAT     4'h8
`define UED_REG_IRQ_STAT 4'hC
// Offsets from 0x10 up need a fifth address bit
`define UED_REG_IRQ_MASK 5'h10
`define UED_REG_LAST_PID 5'h14
// ================================================================
// Descriptor flag byte positions
`define UED_F_OWN    7
`define UED_F_TOGGLE 6
`define UED_F_KEEP   5
`define UED_F_NO_INC 4
`define UED_F_DTS    3
`define UED_F_STALL  2
// ================================================================
// Token PID codes
`define UED_PID_OUT   4'h1
`define UED_PID_IN    4'h9
`define UED_PID_SETUP 4'hD
// ================================================================
// Interrupt bits and reset values
`define UED_IRQ_DONE   0
`define UED_IRQ_SKIP   1
`define UED_BASE_RESET 23'h000000
`endif

// file: verilog/ued_addr_gen.v
// Descriptor address and DMA address generator
`timescale 1ns/1ps
`include "ued_defs.vh"
module ued_addr_gen (
	// Clock and reset
	input  wire        SYS_CLK,
	input  wire        RST,
	// Descriptor address inputs
	input  wire [22:0] table_base,
	input  wire [3:0]  endpoint,
	input  wire        tx,
	input  wire        odd,
	output wire [31:0] desc_addr,
	// DMA address stepping
	input  wire        load,
	input  wire [31:0] start_addr,
	input  wire        step,
	input  wire        no_increment,
	output reg  [31:0] dma_addr
);
	// ================================================================
	// Descriptor entry address, 8-byte entries on a 512-byte table
	assign desc_addr = {table_base, endpoint, tx, odd, 3'h0};
	// ================================================================
	// DMA pointer
	always @(posedge SYS_CLK) begin
		if (RST) begin
			dma_addr <= 32'h00000000;
		end else if (load) begin
			dma_addr <= start_addr;
		end else if (step && !no_increment) begin
			dma_addr <= dma_addr + 32'h00000001;
		end
	end
endmodule

// file: verilog/ued_writeback.v
// Flag byte write-back on token completion
`timescale 1ns/1ps
`include "ued_defs.vh"
module ued_writeback (
	// Descriptor flags as read and completed token
	input  wire [7:0] flags_in,
	input  wire [3:0] token_pid,
	// Flag byte to write back and whether processor is told
	output reg  [7:0] flags_out,
	output wire       notify
);
	wire keep;
	assign keep = flags_in[`UED_F_KEEP];
	assign notify = !keep;
	always @* begin
		flags_out = flags_in;
		if (!keep) begin
			// Toggle bit passes through untouched
			flags_out[`UED_F_OWN]   = 1'b0;
			flags_out[`UED_F_KEEP]  = token_pid[3];
			flags_out[`UED_F_DTS]   = token_pid[1];
			flags_out[`UED_F_STALL] = token_pid[0];
			if (!flags_in[`UED_F_NO_INC]) begin
				flags_out[`UED_F_NO_INC] = token_pid[2];
			end
		end
		// Keep set leaves the byte unchanged and owned
	end
endmodule

// file: verilog/ued_engine.v
// Endpoint descriptor control engine with AXI4-Lite registers
`timescale 1ns/1ps
`include "ued_defs.vh"
module ued_engine (
	// Clock and reset
	input  wire        SYS_CLK,
	input  wire        RST,
	// AXI4-Lite write address
	input  wire [7:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	// AXI4-Lite write data
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	// AXI4-Lite write response
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	// AXI4-Lite read address
	input  wire [7:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	// AXI4-Lite read data
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	// Token from the serial engine
	input  wire        TOKEN_VALID,
	input  wire [3:0]  TOKEN_PID,
	input  wire [3:0]  TOKEN_ENDP,
	input  wire        TOKEN_ODD,
	output wire        TOKEN_READY,
	// Data phase
	input  wire        DATA_STEP,
	input  wire        DATA_LAST,
	output wire        DATA_ACTIVE,
	output wire        DATA_TOGGLE,
	output reg         TOKEN_STALL,
	output wire [31:0] DMA_ADDR,
	// Descriptor memory port
	output reg         MEM_REQ,
	output reg         MEM_WE,
	output reg  [31:0] MEM_ADDR,
	output reg  [7:0]  MEM_WDATA,
	input  wire        MEM_ACK,
	input  wire [31:0] MEM_RDATA,
	// Interrupt
	output wire        IRQ
);
	// ================================================================
	// States
	localparam S_IDLE  = 3'd0;
	localparam S_FLAGS = 3'd1;
	localparam S_ADDR  = 3'd2;
	localparam S_DATA  = 3'd3;
	localparam S_WB    = 3'd4;

	reg  [2:0]  state;
	reg  [3:0]  pid;
	reg  [3:0]  endp;
	reg         odd;
	reg         tx;
	reg  [7:0]  flags;
	wire        load;
	reg         enable;
	reg  [22:0] table_base;
	reg  [1:0]  irq_stat;
	reg  [1:0]  irq_mask;
	reg  [3:0]  last_pid;
	reg  [3:0]  last_endp;
	reg         last_tx;
	reg         last_odd;
	reg  [7:0]  done_count;
	wire [31:0] desc_addr;
	wire [7:0]  flags_out;
	wire        notify;
	reg  [1:0]  irq_set;

	// ================================================================
	// Helpers
	function is_reg;
		input [7:0] a;
		input [7:0] off;
		begin
			is_reg = (a[7:2] == off[7:2]);
		end
	endfunction

	// ================================================================
	// Submodules
	ued_addr_gen u_addr (
		.SYS_CLK      (SYS_CLK),
		.RST          (RST),
		.table_base   (table_base),
		.endpoint     (endp),
		.tx           (tx),
		.odd          (odd),
		.desc_addr    (desc_addr),
		.load         (load),
		.start_addr   (MEM_RDATA),
		.step         (DATA_STEP && state == S_DATA),
		.no_increment (flags[`UED_F_NO_INC]),
		.dma_addr     (DMA_ADDR)
	);

	ued_writeback u_wb (
		.flags_in  (flags),
		.token_pid (pid),
		.flags_out (flags_out),
		.notify    (notify)
	);

	// ================================================================
	// Token engine
	assign TOKEN_READY = (state == S_IDLE) && enable;
	assign DATA_ACTIVE = (state == S_DATA);
	assign DATA_TOGGLE = flags[`UED_F_TOGGLE];
	// Start address stands only in the ack cycle, so load it then
	assign load        = (state == S_ADDR) && MEM_REQ && MEM_ACK;

	always @(posedge SYS_CLK) begin
		if (RST) begin
			state       <= S_IDLE;
			pid         <= 4'h0;
			endp        <= 4'h0;
			odd         <= 1'b0;
			tx          <= 1'b0;
			flags       <= 8'h00;
			MEM_REQ     <= 1'b0;
			MEM_WE      <= 1'b0;
			MEM_ADDR    <= 32'h00000000;
			MEM_WDATA   <= 8'h00;
			TOKEN_STALL <= 1'b0;
			irq_set     <= 2'h0;
			last_pid    <= 4'h0;
			last_endp   <= 4'h0;
			last_tx     <= 1'b0;
			last_odd    <= 1'b0;
			done_count  <= 8'h00;
		end else begin
			irq_set     <= 2'h0;
			TOKEN_STALL <= 1'b0;
			case (state)
			S_IDLE: begin
				if (TOKEN_VALID && enable) begin
					pid     <= TOKEN_PID;
					endp    <= TOKEN_ENDP;
					odd     <= TOKEN_ODD;
					tx      <= (TOKEN_PID == `UED_PID_IN);
					state   <= S_FLAGS;
				end
			end
			S_FLAGS: begin
				// Flag byte sits at byte 4 of the entry
				MEM_REQ  <= 1'b1;
				MEM_WE   <= 1'b0;
				MEM_ADDR <= desc_addr + 32'h00000004;
				if (MEM_REQ && MEM_ACK) begin
					MEM_REQ <= 1'b0;
					if (!MEM_RDATA[`UED_F_OWN]) begin
						// Processor owns it: nothing else is looked at
						state   <= S_IDLE;
						irq_set <= 2'h2;
					end else if (MEM_RDATA[`UED_F_STALL]) begin
						TOKEN_STALL <= 1'b1;
						state       <= S_IDLE;
					end else begin
						flags <= MEM_RDATA[7:0];
						state <= S_ADDR;
					end
				end
			end
			S_ADDR: begin
				MEM_REQ  <= 1'b1;
				MEM_WE   <= 1'b0;
				MEM_ADDR <= desc_addr;
				if (MEM_REQ && MEM_ACK) begin
					MEM_REQ <= 1'b0;
					state   <= S_DATA;
				end
			end
			S_DATA: begin
				if (DATA_LAST) begin
					state <= S_WB;
				end
			end
			S_WB: begin
				MEM_REQ   <= 1'b1;
				MEM_WE    <= 1'b1;
				MEM_ADDR  <= desc_addr + 32'h00000004;
				MEM_WDATA <= flags_out;
				if (MEM_REQ && MEM_ACK) begin
					MEM_REQ <= 1'b0;
					MEM_WE  <= 1'b0;
					state   <= S_IDLE;
					if (notify) begin
						last_pid   <= pid;
						last_endp  <= endp;
						last_tx    <= tx;
						last_odd   <= odd;
						done_count <= done_count + 8'h01;
						irq_set    <= 2'h1;
					end
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// ================================================================
	// AXI4-Lite slave; the engine never arbitrates against the
	// processor for descriptor memory, so nothing is locked out
	reg        aw_held;
	reg        w_held;
	reg [7:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       do_write;
	wire [31:0] st_mask;
	wire [31:0] st;
	genvar      g;

	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign do_write      = aw_held && w_held && !S_AXI_BVALID;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_strb
			assign st_mask[8*g+7:8*g] = {8{w_strb[g]}};
		end
	endgenerate
	assign st = w_data & st_mask;
	assign IRQ = |(irq_stat & irq_mask);

	always @(posedge SYS_CLK) begin
		if (RST) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= 2'h0;
			enable       <= 1'b0;
			table_base   <= `UED_BASE_RESET;
			irq_stat     <= 2'h0;
			irq_mask     <= 2'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
			// Set wins over a write-one clear in the same cycle
			irq_stat <= irq_stat | irq_set;
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= 2'h0;
				if (is_reg(aw_addr, {4'h0, `UED_REG_CTRL})) begin
					if (w_strb[0]) enable <= w_data[0];
				end else if (is_reg(aw_addr, {4'h0, `UED_REG_BASE})) begin
					table_base <= (table_base & ~st_mask[31:9]) | st[31:9];
				end else if (is_reg(aw_addr, {4'h0, `UED_REG_IRQ_STAT})) begin
					irq_stat <= (irq_stat & ~st[1:0]) | irq_set;
				end else if (is_reg(aw_addr, {3'h0, `UED_REG_IRQ_MASK})) begin
					if (w_strb[0]) irq_mask <= w_data[1:0];
				end else if (!is_reg(aw_addr, {4'h0, `UED_REG_STAT}) &&
					!is_reg(aw_addr, {3'h0, `UED_REG_LAST_PID})) begin
					S_AXI_BRESP <= 2'h2;
				end
			end
		end
	end

	always @(posedge SYS_CLK) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= 2'h0;
		end else begin
			if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP  <= 2'h0;
				S_AXI_RDATA  <= 32'h00000000;
				if (is_reg(S_AXI_ARADDR, {4'h0, `UED_REG_CTRL}))
					S_AXI_RDATA <= {31'h0, enable};
				else if (is_reg(S_AXI_ARADDR, {4'h0, `UED_REG_BASE}))
					S_AXI_RDATA <= {table_base, 9'h000};
				else if (is_reg(S_AXI_ARADDR, {4'h0, `UED_REG_STAT}))
					S_AXI_RDATA <= {16'h0, done_count, last_endp,
						last_tx, last_odd, 1'b0, state == S_IDLE};
				else if (is_reg(S_AXI_ARADDR, {4'h0, `UED_REG_IRQ_STAT}))
					S_AXI_RDATA <= {30'h0, irq_stat};
				else if (is_reg(S_AXI_ARADDR, {3'h0, `UED_REG_IRQ_MASK}))
					S_AXI_RDATA <= {30'h0, irq_mask};
				else if (is_reg(S_AXI_ARADDR, {3'h0, `UED_REG_LAST_PID}))
					S_AXI_RDATA <= {28'h0, last_pid};
				else
					S_AXI_RRESP <= 2'h2;
			end
		end
	end
endmodule

// file: bench/ued_mem_model.sv
// Descriptor memory model standing in for shared system RAM
`timescale 1ns/1ps
module ued_mem_model (
	// Clock
	input  wire        SYS_CLK,
	// Engine port
	input  wire        MEM_REQ,
	input  wire        MEM_WE,
	input  wire [31:0] MEM_ADDR,
	input  wire [7:0]  MEM_WDATA,
	output reg         MEM_ACK,
	output reg  [31:0] MEM_RDATA
);
	// Wait states before each answer, set per test for slow memory
	int        lat = 0;
	int        cnt = 0;
	reg [31:0] mem [0:127];
	initial begin
		MEM_ACK = 1'b0;
		MEM_RDATA = 32'h0;
	end
	// Bench may touch mem at any time: access is never locked out
	always @(posedge SYS_CLK) begin
		MEM_ACK <= 1'b0;
		// Read data only valid in the ack cycle, so it churns elsewhere
		MEM_RDATA <= ~MEM_RDATA;
		if (MEM_REQ && !MEM_ACK) begin
			if (cnt < lat)
				cnt <= cnt + 1;
			else begin
				cnt <= 0;
				MEM_ACK <= 1'b1;
				MEM_RDATA <= mem[MEM_ADDR[8:2]];
				if (MEM_WE)
					mem[MEM_ADDR[8:2]][7:0] <= MEM_WDATA;
			end
		end
	end
endmodule

// file: bench/ued_engine_assertions.sv
// Assertions on the descriptor engine ports
`timescale 1ns/1ps
module ued_chk (
	// Clock and reset
	input wire        SYS_CLK,
	input wire        RST,
	// Token and data phase
	input wire        TOKEN_VALID,
	input wire        TOKEN_READY,
	input wire [3:0]  TOKEN_PID,
	input wire [3:0]  TOKEN_ENDP,
	input wire        TOKEN_ODD,
	input wire        DATA_ACTIVE,
	input wire        DATA_STEP,
	input wire        DATA_TOGGLE,
	input wire [31:0] DMA_ADDR,
	// Memory port and interrupt
	input wire        MEM_REQ,
	input wire        MEM_WE,
	input wire [31:0] MEM_ADDR,
	input wire [7:0]  MEM_WDATA,
	input wire        MEM_ACK,
	input wire [31:0] MEM_RDATA,
	input wire        IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// ==============================================================
	// Flags and PID held for the write-back checks
	reg  [7:0] f;
	reg  [3:0] pid;
	wire       rd_f = MEM_REQ && MEM_ACK && !MEM_WE && MEM_ADDR[2];
	wire       wb = MEM_REQ && MEM_ACK && MEM_WE;
	always @(posedge SYS_CLK) begin
		if (rd_f)
			f <= MEM_RDATA[7:0];
		if (TOKEN_VALID && TOKEN_READY)
			pid <= TOKEN_PID;
	end
	property p_addr;
		TOKEN_VALID && TOKEN_READY |-> ##2 MEM_REQ && !MEM_WE &&
		MEM_ADDR[8:0] == {$past(TOKEN_ENDP, 2), $past(TOKEN_PID, 2) == 4'h9,
		$past(TOKEN_ODD, 2), 3'b100};
	endproperty
	a_addr: assert property (p_addr) else $error("flags address wrong");
	property p_own;
		wb |-> MEM_WDATA[7] == f[5];
	endproperty
	a_own: assert property (p_own) else $error("ownership wrong");
	property p_tog;
		wb |-> MEM_WDATA[6] == f[6];
	endproperty
	a_tog: assert property (p_tog) else $error("toggle altered");
	property p_tact;
		DATA_ACTIVE |-> DATA_TOGGLE == f[6];
	endproperty
	a_tact: assert property (p_tact) else $error("toggle output wrong");
	property p_keep;
		wb && f[5] |-> MEM_WDATA == f ##1 (!$rose(IRQ))[*3];
	endproperty
	a_keep: assert property (p_keep) else $error("keep byte changed");
	property p_pid;
		wb && !f[5] |-> MEM_WDATA[5:2] == {pid[3], f[4] | pid[2], pid[1:0]};
	endproperty
	a_pid: assert property (p_pid) else $error("pid write-back wrong");
	property p_skip;
		rd_f && !MEM_RDATA[7] |=> (!DATA_ACTIVE && !(MEM_REQ && MEM_WE))[*4];
	endproperty
	a_skip: assert property (p_skip) else $error("unowned entry used");
	property p_done;
		wb && !f[5] |-> ##[1:4] IRQ;
	endproperty
	a_done: assert property (p_done) else $error("no done interrupt");
	property p_no_increment_flag;
		DATA_ACTIVE && DATA_STEP && f[4] |=> $stable(DMA_ADDR);
	endproperty
	a_no_increment_flag: assert property (p_no_increment_flag) else $error("address moved");
	c_done: cover property (wb && !f[5]);
	c_keep: cover property (wb && f[5]);
	c_skip: cover property (rd_f && !MEM_RDATA[7]);
endmodule
bind ued_engine ued_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
	.TOKEN_VALID(TOKEN_VALID), .TOKEN_READY(TOKEN_READY),
	.TOKEN_PID(TOKEN_PID), .TOKEN_ENDP(TOKEN_ENDP), .TOKEN_ODD(TOKEN_ODD),
	.DATA_ACTIVE(DATA_ACTIVE), .DATA_STEP(DATA_STEP),
	.DATA_TOGGLE(DATA_TOGGLE), .DMA_ADDR(DMA_ADDR), .MEM_REQ(MEM_REQ),
	.MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
	.MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .IRQ(IRQ));

// file: bench/tb.sv
// Self-checking bench for the descriptor engine
`timescale 1ns/1ps
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin \
	fail_count++; $display("BAD %s exp %0h got %0h", n, e, v); end end
module tb;
	reg         SYS_CLK = 0, RST = 1;
	reg  [7:0]  awaddr = 0, araddr = 0;
	reg  [31:0] wdata = 0, rd;
	reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	reg         rready = 0, tvalid = 0, todd = 0, step = 0, last = 0;
	reg  [3:0]  tpid = 0, tendp = 0;
	reg  [1:0]  rr;
	wire        awready, wready, bvalid, arready, rvalid, tready, act;
	wire        tog, stall, mreq, mwe, mack, irq;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata, dma, maddr, mrdata;
	wire [7:0]  mwdata;
	int         fail_count = 0, checks_done = 0, i;
	// Rows: pid, endpoint (bit0 is odd), flags, byte back, irq status
	reg  [25:0] rows [0:6] = '{{4'h1, 4'h1, 8'h80, 8'h04, 2'h1},
		{4'h9, 4'h2, 8'hC0, 8'h64, 2'h1}, {4'hD, 4'h3, 8'h90, 8'h34, 2'h1},
		{4'h1, 4'h4, 8'h00, 8'h00, 2'h2}, {4'h9, 4'h5, 8'hF0, 8'hF0, 2'h0},
		{4'h1, 4'h6, 8'h84, 8'h84, 2'h0}, {4'hD, 4'hF, 8'hC0, 8'h74, 2'h1}};
	always #5 SYS_CLK = ~SYS_CLK;
	ued_engine dut (.SYS_CLK(SYS_CLK), .RST(RST), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .TOKEN_VALID(tvalid), .TOKEN_PID(tpid),
		.TOKEN_ENDP(tendp), .TOKEN_ODD(todd), .TOKEN_READY(tready),
		.DATA_STEP(step), .DATA_LAST(last), .DATA_ACTIVE(act),
		.DATA_TOGGLE(tog), .TOKEN_STALL(stall), .DMA_ADDR(dma),
		.MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(maddr), .MEM_WDATA(mwdata),
		.MEM_ACK(mack), .MEM_RDATA(mrdata), .IRQ(irq));
	ued_mem_model mm (.SYS_CLK(SYS_CLK), .MEM_REQ(mreq), .MEM_WE(mwe),
		.MEM_ADDR(maddr), .MEM_WDATA(mwdata), .MEM_ACK(mack),
		.MEM_RDATA(mrdata));
	// ==============================================================
	// Bus tasks: each waits for a rising edge, then drives just after it
	task automatic axw(input [7:0] a, input [31:0] d);
		bit ha, hw, hb;
		begin
			@(posedge SYS_CLK);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1;
			wvalid <= 1;
			bready <= 1;
			do begin
				@(negedge SYS_CLK);
				ha = awvalid && awready;
				hw = wvalid && wready;
				hb = bvalid;
				rr = bresp;
				@(posedge SYS_CLK);
				if (ha)
					awvalid <= 0;
				if (hw)
					wvalid <= 0;
			end while (!hb);
			bready <= 0;
		end
	endtask
	task automatic axr(input [7:0] a);
		bit ha, hr;
		begin
			@(posedge SYS_CLK);
			araddr <= a;
			arvalid <= 1;
			rready <= 1;
			do begin
				@(negedge SYS_CLK);
				ha = arvalid && arready;
				hr = rvalid;
				rd = rdata;
				rr = rresp;
				@(posedge SYS_CLK);
				if (ha)
					arvalid <= 0;
			end while (!hr);
			rready <= 0;
		end
	endtask
	// One token: three back-to-back steps then last
	task automatic run_row(input [25:0] r);
		int k, s;
		bit b;
		logic st;
		reg [6:0] w;
		reg [31:0] d0;
		begin
			w = {r[21:18], r[25:22] == 4'h9, r[18], 1'b0};
			d0 = {20'h00010, r[21:18], 8'h00};
			s = 0;
			st = 0;
			mm.mem[w] = d0;
			mm.mem[w + 1] = {24'h0, r[17:10]};
			mm.lat = r[18] ? 3 : 0;
			@(posedge SYS_CLK);
			tvalid <= 1;
			tpid <= r[25:22];
			tendp <= r[21:18];
			todd <= r[18];
			do @(negedge SYS_CLK); while (!tready);
			@(posedge SYS_CLK);
			tvalid <= 0;
			// Entry left alone until ownership returns
			for (k = 0; k < 80; k++) begin
				@(negedge SYS_CLK);
				st = st | stall;
				if (k > 3 && tready && !act)
					break;
				b = act && s < 5;
				if (b && s == 0)
					`CHK("toggle", r[16], tog)
				if (b && s == 4)
					`CHK("dma", d0 + (r[14] ? 0 : 3), dma)
				@(posedge SYS_CLK);
				step <= b && s < 3;
				last <= b && s == 3;
				s = s + b;
			end
			`CHK("stall", r[17] & r[12], st)
			`CHK("flags", r[9:2], mm.mem[w + 1][7:0])
			axr(8'h0C);
			`CHK("irq_stat", r[1:0], rd[1:0])
			`CHK("irq", |r[1:0], irq)
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		fail_count++;
		give_verdict;
	end
	initial begin
		repeat (12) @(posedge SYS_CLK);
		RST <= 0;
		axr(8'h0C);
		`CHK("irq_stat_rst", 2'h0, rd[1:0])
		`CHK("irq_rst", 1'b0, irq)
		axr(8'h40);
		`CHK("rresp", 2'h2, rr)
		axw(8'h40, 32'h0);
		`CHK("bresp", 2'h2, rr)
		$display("reset and bus test done");
		axw(8'h10, 32'h3);
		axw(8'h00, 32'h1);
		axw(8'h04, 32'h12345655);
		axr(8'h04);
		`CHK("base", 32'h12345600, rd)
		axw(8'h04, 32'h0);
		axr(8'h04);
		`CHK("base_clr", 32'h0, rd)
		$display("base register test done");
		// Keep rows also carry no-increment
		for (i = 0; i < 7; i++) begin
			run_row(rows[i]);
			if (i == 0) begin
				axr(8'h08);
				`CHK("stat", 32'h115, rd)
				axr(8'h14);
				`CHK("last_pid", 4'h1, rd[3:0])
				axw(8'h10, 32'h0);
				`CHK("irq_masked", 1'b0, irq)
				axw(8'h10, 32'h3);
				`CHK("irq_unmasked", 1'b1, irq)
			end
			axw(8'h0C, 32'h3);
			`CHK("irq_clear", 1'b0, irq)
			$display("row %0d done", i);
		end
		// Reset in mid-run drops enable, mask and counters
		@(posedge SYS_CLK);
		RST <= 1;
		repeat (3) @(posedge SYS_CLK);
		RST <= 0;
		axr(8'h00);
		`CHK("ctrl_rst", 32'h0, rd)
		`CHK("tready_rst", 1'b0, tready)
		axr(8'h10);
		`CHK("mask_rst", 32'h0, rd)
		axr(8'h08);
		`CHK("stat_rst", 32'h1, rd)
		$display("mid-run reset test done");
		give_verdict;
	end
endmodule
